// ### pifb_bank.v
// Behaviour
// - a flag sets on its event regardless of any enable bit.
// - no peripheral request reaches the core while the peripheral gate is clear.
// - enable_four bit1 enables port2 collision, bit0 port2 transfer.
// - unimplemented bits ignore writes and read as zero.
// - flags_one holds timer1 gate down to timer1 overflow, bit7 to bit0.
// - serial rx and tx flags at bits 5,4 are read-only.
// - flags_two holds osc fail, comparators, eeprom, port1 collision, capture2.
// - flags_three holds capture4, capture3, timer6 and timer4 match flags.
// - every implemented enable and flag bit clears on any reset, except serial rx and tx, which follow their inputs.
// - enable_four, flags_three, capture2 exist only in the larger variant.
// - an enabled pending flag wakes from sleep while the peripheral gate is set, even with global gate clear.
`timescale 1ns/1ps
`default_nettype none
`include "pifb_consts.vh"

module pifb_bank
#(
  parameter LARGE_VARIANT = 1
)
(
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // peripheral event pulses
  input wire [7:0] set_flags_one,
  input wire [7:0] set_flags_two,
  input wire [7:0] set_flags_three,
  // serial status levels
  input wire serial_rx_flag,
  input wire serial_tx_flag,
  // neighbouring enables and port2 flags
  input wire [7:0] enable_one,
  input wire [7:0] enable_two,
  input wire [7:0] enable_three,
  input wire [1:0] port2_flags,
  // requests to the core
  output wire periph_irq_req,
  output wire wake_req,
  output wire irq
);

  // ****************************************************************
  // variant masks
  // ****************************************************************
  localparam [7:0] MASK_EN4 = LARGE_VARIANT ? `PIFB_MASK_ENABLE_FOUR :
    `PIFB_MASK_NONE;
  localparam [7:0] MASK_F2 = LARGE_VARIANT ? `PIFB_MASK_FLAGS_TWO_BIG :
    `PIFB_MASK_FLAGS_TWO_SMALL;
  localparam [7:0] MASK_F3 = LARGE_VARIANT ? `PIFB_MASK_FLAGS_THREE :
    `PIFB_MASK_NONE;
  localparam [7:0] MASK_E3 = LARGE_VARIANT ? 8'hff : `PIFB_MASK_NONE;

  // ****************************************************************
  // write channel
  // ****************************************************************
  reg aw_held_q;
  reg [7:0] aw_addr_q;
  reg w_held_q;
  reg [7:0] w_data_q;
  reg w_lane_q;
  wire wr_go;
  wire wr_lane;
  reg wr_hit;

  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
  assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_lane = wr_go & w_lane_q;

  // hold address and data, taken in either order
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_go)
      begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      else if (wr_go)
      begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write address decode
  reg we_en4;
  reg we_f1;
  reg we_f2;
  reg we_f3;
  reg we_ctrl;
  reg we_clr;
  reg we_ien;
  always @*
  begin
    we_en4 = 1'b0;
    we_f1 = 1'b0;
    we_f2 = 1'b0;
    we_f3 = 1'b0;
    we_ctrl = 1'b0;
    we_clr = 1'b0;
    we_ien = 1'b0;
    wr_hit = 1'b1;
    if (aw_addr_q[7:2] == `PIFB_OFS_ENABLE_FOUR >> 2)
      we_en4 = wr_lane;
    else if (aw_addr_q[7:2] == `PIFB_OFS_FLAGS_ONE >> 2)
      we_f1 = wr_lane;
    else if (aw_addr_q[7:2] == `PIFB_OFS_FLAGS_TWO >> 2)
      we_f2 = wr_lane;
    else if (aw_addr_q[7:2] == `PIFB_OFS_FLAGS_THREE >> 2)
      we_f3 = wr_lane;
    else if (aw_addr_q[7:2] == `PIFB_OFS_CORE_CTRL >> 2)
      we_ctrl = wr_lane;
    else if (aw_addr_q[7:2] == `PIFB_OFS_IRQ_STATUS >> 2)
      wr_hit = 1'b1; // read-only, write ignored
    else if (aw_addr_q[7:2] == `PIFB_OFS_IRQ_CLEAR >> 2)
      we_clr = wr_lane;
    else if (aw_addr_q[7:2] == `PIFB_OFS_IRQ_ENABLE >> 2)
      we_ien = wr_lane;
    else
      wr_hit = 1'b0;
  end

  // write response, one per write
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PIFB_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `PIFB_RESP_OKAY : `PIFB_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // register storage
  // ****************************************************************
  wire [7:0] en4_q;
  wire [7:0] f1_q;
  wire [7:0] f2_q;
  wire [7:0] f3_q;
  wire [7:0] ctrl_q;
  wire [7:0] ien_q;

  // port2 enables, larger variant only
  pifb_flag_reg #(.MASK(MASK_EN4)) u_en4
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(we_en4),
    .wr_data(w_data_q),
    .set_in(`PIFB_RESET_BYTE),
    .value_q(en4_q)
  );

  // flags_one, rx and tx bits kept out
  pifb_flag_reg #(.MASK(`PIFB_MASK_FLAGS_ONE_RW)) u_f1
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(we_f1),
    .wr_data(w_data_q),
    .set_in(set_flags_one),
    .value_q(f1_q)
  );

  // flags_two, capture2 only when large
  pifb_flag_reg #(.MASK(MASK_F2)) u_f2
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(we_f2),
    .wr_data(w_data_q),
    .set_in(set_flags_two),
    .value_q(f2_q)
  );

  // flags_three, larger variant only
  pifb_flag_reg #(.MASK(MASK_F3)) u_f3
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(we_f3),
    .wr_data(w_data_q),
    .set_in(set_flags_three),
    .value_q(f3_q)
  );

  // core control: global and peripheral gates
  pifb_flag_reg #(.MASK(`PIFB_MASK_CORE_CTRL)) u_ctrl
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(we_ctrl),
    .wr_data(w_data_q),
    .set_in(`PIFB_RESET_BYTE),
    .value_q(ctrl_q)
  );

  // interrupt enable of the block itself
  pifb_flag_reg #(.MASK(`PIFB_MASK_IRQ)) u_ien
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(we_ien),
    .wr_data(w_data_q),
    .set_in(`PIFB_RESET_BYTE),
    .value_q(ien_q)
  );

  // ****************************************************************
  // request combine
  // ****************************************************************
  wire [7:0] f1_view;
  wire [7:0] port2_view;
  wire any_pending;
  wire global_gate;
  wire periph_gate;

  // rx and tx follow the serial status directly
  assign f1_view = {f1_q[7:6], serial_rx_flag, serial_tx_flag, f1_q[3:0]};
  assign port2_view = LARGE_VARIANT ? {6'h00, port2_flags} : 8'h00;
  assign any_pending = |(f1_view & enable_one) |
    |(f2_q & enable_two & MASK_F2) |
    |(f3_q & enable_three & MASK_E3) |
    |(port2_view & en4_q);
  assign global_gate = ctrl_q[`PIFB_BIT_GLOBAL_GATE];
  assign periph_gate = ctrl_q[`PIFB_BIT_PERIPH_GATE];
  assign periph_irq_req = any_pending & periph_gate & global_gate;
  assign wake_req = any_pending & periph_gate;

  // ****************************************************************
  // block interrupt status
  // ****************************************************************
  reg req_seen_q;
  reg wake_seen_q;
  reg [7:0] stat_q;
  reg [7:0] stat_d;
  reg [7:0] stat_set;
  reg rd_miss;
  wire rd_take;

  // rising edges of request and wake, decode misses
  always @*
  begin
    stat_set = 8'h00;
    stat_set[`PIFB_BIT_EV_REQUEST] = periph_irq_req & ~req_seen_q;
    stat_set[`PIFB_BIT_EV_WAKE] = wake_req & ~wake_seen_q;
    stat_set[`PIFB_BIT_EV_DECODE] = (wr_go & ~wr_hit) | (rd_take & rd_miss);
    stat_d = stat_q;
    if (we_clr)
      stat_d = stat_q & ~w_data_q;
    stat_d = stat_d | stat_set; // set wins over clear
  end

  // sticky status and edge history
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stat_q <= `PIFB_RESET_BYTE;
      req_seen_q <= 1'b0;
      wake_seen_q <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      req_seen_q <= periph_irq_req;
      wake_seen_q <= wake_req;
    end
  end

  assign irq = |(stat_q & ien_q);

  // ****************************************************************
  // read channel
  // ****************************************************************
  reg [7:0] rd_byte;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take = s_axi_arvalid & s_axi_arready;

  // read decode, unimplemented bits read zero
  always @*
  begin
    rd_byte = 8'h00;
    rd_miss = 1'b0;
    if (s_axi_araddr[7:2] == `PIFB_OFS_ENABLE_FOUR >> 2)
      rd_byte = en4_q;
    else if (s_axi_araddr[7:2] == `PIFB_OFS_FLAGS_ONE >> 2)
      rd_byte = f1_view;
    else if (s_axi_araddr[7:2] == `PIFB_OFS_FLAGS_TWO >> 2)
      rd_byte = f2_q;
    else if (s_axi_araddr[7:2] == `PIFB_OFS_FLAGS_THREE >> 2)
      rd_byte = f3_q;
    else if (s_axi_araddr[7:2] == `PIFB_OFS_CORE_CTRL >> 2)
      rd_byte = ctrl_q;
    else if (s_axi_araddr[7:2] == `PIFB_OFS_IRQ_STATUS >> 2)
      rd_byte = stat_q;
    else if (s_axi_araddr[7:2] == `PIFB_OFS_IRQ_CLEAR >> 2)
      rd_byte = 8'h00; // write-only
    else if (s_axi_araddr[7:2] == `PIFB_OFS_IRQ_ENABLE >> 2)
      rd_byte = ien_q;
    else
      rd_miss = 1'b1;
  end

  // read data registered one cycle after the address
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PIFB_RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_miss ? `PIFB_RESP_SLVERR : `PIFB_RESP_OKAY;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // pifb_bank

`default_nettype wire

// ### pifb_consts.vh
`ifndef PIFB_CONSTS_VH
`define PIFB_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PIFB_OFS_ENABLE_FOUR 8'h00
`define PIFB_OFS_FLAGS_ONE 8'h04
`define PIFB_OFS_FLAGS_TWO 8'h08
`define PIFB_OFS_FLAGS_THREE 8'h0c
`define PIFB_OFS_CORE_CTRL 8'h10
`define PIFB_OFS_IRQ_STATUS 8'h14
`define PIFB_OFS_IRQ_CLEAR 8'h18
`define PIFB_OFS_IRQ_ENABLE 8'h1c

// ****************************************************************
// implemented-bit masks
// ****************************************************************
`define PIFB_MASK_ENABLE_FOUR 8'h03
`define PIFB_MASK_FLAGS_ONE_RW 8'hcf
`define PIFB_MASK_FLAGS_TWO_BIG 8'hf9
`define PIFB_MASK_FLAGS_TWO_SMALL 8'hf8
`define PIFB_MASK_FLAGS_THREE 8'h3a
`define PIFB_MASK_NONE 8'h00
`define PIFB_MASK_CORE_CTRL 8'hc0
`define PIFB_MASK_IRQ 8'h07

// ****************************************************************
// field positions
// ****************************************************************
`define PIFB_BIT_COLLISION2_EN 1
`define PIFB_BIT_TRANSFER2_EN 0
`define PIFB_BIT_SERIAL_RX 5
`define PIFB_BIT_SERIAL_TX 4
`define PIFB_BIT_GLOBAL_GATE 7
`define PIFB_BIT_PERIPH_GATE 6
`define PIFB_BIT_EV_REQUEST 0
`define PIFB_BIT_EV_WAKE 1
`define PIFB_BIT_EV_DECODE 2

// ****************************************************************
// reset values and bus answers
// ****************************************************************
`define PIFB_RESET_BYTE 8'h00
`define PIFB_RESP_OKAY 2'b00
`define PIFB_RESP_SLVERR 2'b10

`endif

// ### pifb_flag_reg.v
`timescale 1ns/1ps
`default_nettype none
`include "pifb_consts.vh"

// ****************************************************************
// one 8-bit register, hardware sets, software writes
// ****************************************************************
module pifb_flag_reg
#(
  parameter [7:0] MASK = 8'hff
)
(
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // software write
  input wire wr_en,
  input wire [7:0] wr_data,
  // hardware set pulses
  input wire [7:0] set_in,
  // stored value
  output reg [7:0] value_q
);

  reg [7:0] value_d;

  // a set in the write cycle still lands
  always @*
  begin
    value_d = value_q | (set_in & MASK);
    if (wr_en)
    begin
      value_d = (wr_data & MASK) | (set_in & MASK);
    end
  end

  // all bits clear on any reset
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      value_q <= `PIFB_RESET_BYTE;
    end
    else
    begin
      value_q <= value_d;
    end
  end

endmodule // pifb_flag_reg

`default_nettype wire

// ### pifb_bank_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "pifb_consts.vh"
// ****
// bus and request checks
// ****
module pifb_bank_sva
(
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // write channels
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // read channels
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // requests
  input wire periph_irq_req,
  input wire wake_req,
  input wire irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // handshake events
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  // full request implies the gated wake
  req_wake_a: assert property (periph_irq_req |-> wake_req)
    else $error("request without wake");
  upper_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  write_refuse_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer open");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer open");
  // answer one cycle later, error above the map
  read_answer_a: assert property (ar_take |=> s_axi_rvalid
    && s_axi_rresp == ($past(s_axi_araddr) > 8'h1f ?
    `PIFB_RESP_SLVERR : `PIFB_RESP_OKAY))
    else $error("read answer wrong");
  write_answer_a: assert property (wr_take |=> b_late)
    else $error("write answer late");
  reset_clear_a: assert property ($fell(rst) |-> !irq
    && !wake_req && !s_axi_bvalid && !s_axi_rvalid)
    else $error("state after reset");
endmodule // pifb_bank_sva

bind pifb_bank pifb_bank_sva u_pifb_bank_sva (.*);
`default_nettype wire

// ### pifb_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// peripheral event sources
// ****
module pifb_src_model
(
  // clock
  input wire ref_clk,
  // command from bench
  input wire fire,
  input wire [7:0] pat,
  // event pulses
  output logic [7:0] set_flags_one,
  output logic [7:0] set_flags_two,
  output logic [7:0] set_flags_three
);
  // one-cycle pulses, low between events
  always @(posedge ref_clk)
  begin
    set_flags_one <= fire ? pat : 8'h00;
    set_flags_two <= fire ? pat : 8'h00;
    set_flags_three <= fire ? pat : 8'h00;
  end
endmodule // pifb_src_model
`default_nettype wire

// ### pifb_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pifb_consts.vh"
// ****
// bench
// ****
module pifb_bank_bench;
  logic ref_clk = 0, rst = 1, fire = 0, serial_rx_flag = 0;
  logic serial_tx_flag = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, pat = 8'hff;
  logic [7:0] enable_one = 0, enable_two = 0, enable_three = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] port2_flags = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, periph_irq_req, wake_req, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] set_flags_one, set_flags_two, set_flags_three;
  integer n_errors = 0, comparisons = 0;
  logic [7:0] ofs [4] = '{`PIFB_OFS_ENABLE_FOUR, `PIFB_OFS_FLAGS_ONE,
    `PIFB_OFS_FLAGS_TWO, `PIFB_OFS_FLAGS_THREE};
  logic [7:0] msk [4] = '{8'h03, 8'hcf, 8'hf9, 8'h3a};

  pifb_bank u_pifb_bank (.*);
  pifb_src_model u_pifb_src_model (.*);

  // clock
  always #10 ref_clk = ~ref_clk;

  task end_of_test;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons++;
      if (got !== exp)
      begin
        n_errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // bounded wait ran out
  task hang;
    begin
      n_errors++;
      end_of_test;
    end
  endtask

  task automatic wr(input [7:0] a, input [7:0] d, output [1:0] r);
    integer i;
    begin
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (i = 0; i < 50; i++)
      begin
        @(posedge ref_clk);
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
        if (s_axi_bvalid) break;
      end
      if (i == 50) hang;
      r = s_axi_bresp;
      s_axi_bready <= 0;
    end
  endtask

  task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
    integer i;
    begin
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (i = 0; i < 50; i++)
      begin
        @(posedge ref_clk);
        if (s_axi_arready) s_axi_arvalid <= 0;
        if (s_axi_rvalid) break;
      end
      if (i == 50) hang;
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
    end
  endtask

  // write expecting OKAY, read expecting a byte
  task automatic w(input [7:0] a, input [7:0] d);
    logic [1:0] r;
    begin
      wr(a, d, r);
      chk(r, `PIFB_RESP_OKAY);
    end
  endtask

  task automatic rc(input [7:0] a, input [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    begin
      rd(a, d, r);
      chk(d, {24'h0, e});
    end
  endtask

  task fire_ev;
    begin
      @(posedge ref_clk) fire <= 1;
      @(posedge ref_clk) fire <= 0;
      repeat (3) @(posedge ref_clk);
    end
  endtask

  task t_masks;
    integer k;
    begin
      for (k = 0; k < 4; k++)
      begin
        rc(ofs[k], 8'h00);
        w(ofs[k], 8'hff);
        rc(ofs[k], msk[k]);
        w(ofs[k], 8'h00);
        rc(ofs[k], 8'h00);
      end
    end
  endtask

  task t_events;
    integer k;
    begin
      fire_ev;
      for (k = 1; k < 4; k++)
        rc(ofs[k], msk[k]);
      @(posedge ref_clk) enable_one <= 8'h01;
      repeat (2) @(posedge ref_clk);
      chk(wake_req, 0);
      w(`PIFB_OFS_CORE_CTRL, 8'h40);
      chk(wake_req, 1);
      chk(periph_irq_req, 0);
      w(`PIFB_OFS_CORE_CTRL, 8'hc0);
      chk(periph_irq_req, 1);
      w(`PIFB_OFS_IRQ_ENABLE, 8'h01);
      chk(irq, 1);
      w(`PIFB_OFS_IRQ_CLEAR, 8'h07);
      chk(irq, 0);
      w(`PIFB_OFS_IRQ_ENABLE, 8'h00);
      w(`PIFB_OFS_CORE_CTRL, 8'h00);
      w(`PIFB_OFS_CORE_CTRL, 8'hc0);
      rc(`PIFB_OFS_IRQ_STATUS, 8'h03);
      chk(irq, 0);
      w(`PIFB_OFS_IRQ_ENABLE, 8'h02);
      chk(irq, 1);
      w(`PIFB_OFS_FLAGS_ONE, 8'h00);
      chk(periph_irq_req, 0);
      w(`PIFB_OFS_FLAGS_TWO, 8'h00);
      w(`PIFB_OFS_FLAGS_THREE, 8'h00);
      @(posedge ref_clk) enable_one <= 8'h00;
    end
  endtask

  task t_port2;
    begin
      @(posedge ref_clk) port2_flags <= 2'b10;
      w(`PIFB_OFS_ENABLE_FOUR, 8'h01);
      chk(periph_irq_req, 0);
      w(`PIFB_OFS_ENABLE_FOUR, 8'h02);
      chk(periph_irq_req, 1);
      @(posedge ref_clk) port2_flags <= 2'b01;
      @(posedge ref_clk);
      chk(periph_irq_req, 0);
      w(`PIFB_OFS_ENABLE_FOUR, 8'h01);
      chk(periph_irq_req, 1);
      w(`PIFB_OFS_ENABLE_FOUR, 8'h00);
    end
  endtask

  task t_serial;
    logic [1:0] r;
    logic [31:0] d;
    begin
      @(posedge ref_clk) serial_rx_flag <= 1;
      w(`PIFB_OFS_FLAGS_ONE, 8'hff);
      rc(`PIFB_OFS_FLAGS_ONE, 8'hef);
      w(`PIFB_OFS_FLAGS_ONE, 8'h00);
      rc(`PIFB_OFS_FLAGS_ONE, 8'h20);
      @(posedge ref_clk) serial_rx_flag <= 0;
      w(`PIFB_OFS_IRQ_CLEAR, 8'h07);
      wr(8'h40, 8'h5a, r);
      chk(r, `PIFB_RESP_SLVERR);
      rd(8'h44, d, r);
      chk(r, `PIFB_RESP_SLVERR);
      rc(`PIFB_OFS_IRQ_STATUS, 8'h04);
    end
  endtask

  // second reset in mid-run
  task t_rereset;
    begin
      fire_ev;
      @(posedge ref_clk) rst <= 1;
      repeat (3) @(posedge ref_clk);
      rst <= 0;
      rc(`PIFB_OFS_FLAGS_ONE, 8'h00);
      rc(`PIFB_OFS_CORE_CTRL, 8'h00);
    end
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 0;
    t_masks;
    t_events;
    t_port2;
    t_serial;
    t_rereset;
    end_of_test;
  end
endmodule // pifb_bank_bench
`default_nettype wire
